// ---- frps_pkg.sv ----
// Constants shared by the flash row program sequencer.
// Assumes a 50 MHz clock and one register index per aligned 32-bit word.

package frps_pkg;

	// ----------------------------------------
	// Register map (index, byte address = 4 x index)
	// ----------------------------------------
	localparam logic [15:0] FLASH_CONTROL_IDX = 16'hFE08;
	localparam logic [15:0] FLASH_BLOCK_PROTECT_IDX = 16'hFF7E;
	localparam logic [15:0] SEQ_STATUS_IDX = 16'hFE10;
	localparam logic [15:0] ARRAY_BASE_IDX = 16'h8000;

	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int CTL_PGM_BIT = 0;
	localparam int CTL_HIGH_VOLTAGE_ENABLE_BIT_BIT = 3;
	localparam int ST_STATE_LSB = 0;
	localparam int ST_BP_READ_BIT = 3;
	localparam int ST_ROW_SEL_BIT = 4;
	localparam int ST_TIMING_ERR_BIT = 5;
	localparam int ST_BUSY_BIT = 6;
	localparam logic [7:0] BP_RESET = 8'hFF;
	localparam int ROW_BYTES = 32;
	localparam int ROW_SHIFT = 5;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 20;
	localparam int HV_SETUP_WAIT_NS = 10000;
	localparam int PROGRAM_SETUP_WAIT_NS = 5000;
	localparam int BYTE_PROGRAM_TIME_NS = 30000;
	localparam int HV_HOLD_WAIT_NS = 5000;
	localparam int READ_RECOVERY_WAIT_NS = 1000;
	localparam int CNT_W = 11;
	localparam logic [CNT_W-1:0] HV_SETUP_CYC = CNT_W'((HV_SETUP_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] PROG_SETUP_CYC = CNT_W'((PROGRAM_SETUP_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] BYTE_PROG_CYC = CNT_W'((BYTE_PROGRAM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] HV_HOLD_CYC = CNT_W'((HV_HOLD_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] RECOVERY_CYC = CNT_W'((READ_RECOVERY_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// ----------------------------------------
	// Bus responses and sequencer states
	// ----------------------------------------
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	typedef enum logic [2:0] {
		FRPS_IDLE = 3'h0,
		FRPS_ARMED = 3'h1,
		FRPS_HV_SETUP = 3'h3,
		FRPS_PROG_SETUP = 3'h2,
		FRPS_PROGRAM = 3'h6,
		FRPS_HV_HOLD = 3'h7,
		FRPS_RECOVER = 3'h5
	} frps_state_e;

endpackage : frps_pkg

// ---- frps_top.sv ----
// Flash row program sequencer with its AXI4-Lite register and array window.
// Assumes one master, at most one write and one read outstanding.
//
// The AXI4-Lite register port was decided locally.

`timescale 1ns/1ns

module frps_top
	import frps_pkg::*;
#(
	parameter int ADDR_W = 18,
	parameter int ARRAY_BYTES = 8192
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic program_arm,
	output logic high_voltage_enable,
	output logic array_readable
);

	localparam int OFF_W = $clog2(ARRAY_BYTES);
	localparam int ROW_W = OFF_W - ROW_SHIFT;

	// ----------------------------------------
	// Storage and state
	// ----------------------------------------
	logic [7:0] flash_mem [ARRAY_BYTES];
	logic [ADDR_W-1:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic aw_have_r;
	logic w_have_r;
	logic program_arm_bit_r;
	logic high_voltage_enable_bit_r;
	logic [7:0] flash_block_protect_r;
	frps_state_e state_r;
	frps_state_e state_nxt;
	logic [CNT_W-1:0] cnt_r;
	logic cnt_ld;
	logic [CNT_W-1:0] cnt_val;
	logic [ROW_W-1:0] row_r;
	logic row_sel_r;
	logic bp_read_r;
	logic timing_err_r;
	logic timing_err_set;
	logic byte_accept;
	logic row_accept;

	// ----------------------------------------
	// Write decode
	// ----------------------------------------
	logic wr_go;
	logic [15:0] wr_idx;
	logic [15:0] wr_arr_idx;
	logic [OFF_W-1:0] wr_off;
	logic wr_ctl;
	logic wr_bp;
	logic wr_st;
	logic wr_arr;
	logic pgm_wr_val;
	logic high_voltage_enable_bit_wr_val;
	logic pgm_set;
	logic pgm_clr;
	logic high_voltage_enable_bit_set;
	logic high_voltage_enable_bit_clr;
	logic in_row;

	assign wr_go = aw_have_r && w_have_r && !s_axi_bvalid;
	assign wr_idx = 16'(awaddr_r[ADDR_W-1:2]);
	assign wr_arr_idx = wr_idx - ARRAY_BASE_IDX;
	assign wr_off = wr_arr_idx[OFF_W-1:0];
	assign wr_ctl = wr_go && wr_idx == FLASH_CONTROL_IDX && wstrb_r[0];
	assign wr_bp = wr_go && wr_idx == FLASH_BLOCK_PROTECT_IDX && wstrb_r[0];
	assign wr_st = wr_go && wr_idx == SEQ_STATUS_IDX && wstrb_r[0];
	assign wr_arr = wr_go && wr_idx >= ARRAY_BASE_IDX && 32'(wr_arr_idx) < ARRAY_BYTES && wstrb_r[0];
	assign pgm_wr_val = wdata_r[CTL_PGM_BIT];
	assign high_voltage_enable_bit_wr_val = wdata_r[CTL_HIGH_VOLTAGE_ENABLE_BIT_BIT];
	assign pgm_set = wr_ctl && pgm_wr_val && !program_arm_bit_r;
	assign pgm_clr = wr_ctl && !pgm_wr_val && program_arm_bit_r;
	assign high_voltage_enable_bit_set = wr_ctl && high_voltage_enable_bit_wr_val && !high_voltage_enable_bit_r;
	assign high_voltage_enable_bit_clr = wr_ctl && !high_voltage_enable_bit_wr_val && high_voltage_enable_bit_r;
	assign in_row = wr_off[OFF_W-1:ROW_SHIFT] == row_r;

	// ----------------------------------------
	// Sequencer next state
	// ----------------------------------------
	// The device only checks least waits; the longest byte time is the
	// software's burden since no figure bounds it here.
	always_comb begin
		state_nxt = state_r;
		cnt_ld = 1'b0;
		cnt_val = cnt_r;
		timing_err_set = 1'b0;
		byte_accept = 1'b0;
		row_accept = 1'b0;
		unique case (state_r)
			FRPS_IDLE: begin
				if (pgm_set) begin
					state_nxt = FRPS_ARMED;
				end
			end
			FRPS_ARMED: begin
				if (wr_arr) begin
					row_accept = 1'b1;
					state_nxt = FRPS_HV_SETUP;
					cnt_ld = 1'b1;
					cnt_val = HV_SETUP_CYC;
				end else if (pgm_clr) begin
					state_nxt = FRPS_IDLE;
				end
			end
			FRPS_HV_SETUP: begin
				if (high_voltage_enable_bit_set) begin
					timing_err_set = cnt_r != '0;
					state_nxt = FRPS_PROG_SETUP;
					cnt_ld = 1'b1;
					cnt_val = PROG_SETUP_CYC;
				end else if (pgm_clr) begin
					state_nxt = FRPS_IDLE;
				end
			end
			FRPS_PROG_SETUP, FRPS_PROGRAM: begin
				if (pgm_clr) begin
					timing_err_set = cnt_r != '0;
					state_nxt = FRPS_HV_HOLD;
					cnt_ld = 1'b1;
					cnt_val = HV_HOLD_CYC;
				end else if (high_voltage_enable_bit_clr) begin
					timing_err_set = 1'b1;
					state_nxt = FRPS_RECOVER;
					cnt_ld = 1'b1;
					cnt_val = RECOVERY_CYC;
				end else if (wr_arr) begin
					if (cnt_r == '0 && in_row) begin
						byte_accept = 1'b1;
						state_nxt = FRPS_PROGRAM;
						cnt_ld = 1'b1;
						cnt_val = BYTE_PROG_CYC;
					end else begin
						timing_err_set = 1'b1;
					end
				end
			end
			FRPS_HV_HOLD: begin
				if (high_voltage_enable_bit_clr) begin
					timing_err_set = cnt_r != '0;
					state_nxt = FRPS_RECOVER;
					cnt_ld = 1'b1;
					cnt_val = RECOVERY_CYC;
				end
			end
			FRPS_RECOVER: begin
				if (cnt_r == '0) begin
					state_nxt = FRPS_IDLE;
				end
			end
			default: begin
				state_nxt = FRPS_IDLE;
			end
		endcase
	end

	// ----------------------------------------
	// Sequencer registers
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			state_r <= FRPS_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			cnt_r <= '0;
		end else if (cnt_ld) begin
			cnt_r <= cnt_val;
		end else if (cnt_r != '0) begin
			cnt_r <= cnt_r - 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			row_r <= '0;
			row_sel_r <= 1'b0;
		end else if (row_accept) begin
			row_r <= wr_off[OFF_W-1:ROW_SHIFT];
			row_sel_r <= 1'b1;
		end else if (state_r == FRPS_IDLE) begin
			row_sel_r <= 1'b0;
		end
	end

	// Only accepted bytes reach the cells; no other array write has effect
	always_ff @(posedge clk) begin
		if (byte_accept) begin
			flash_mem[wr_off] <= wdata_r[7:0];
		end
	end

	// ----------------------------------------
	// Software registers
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			program_arm_bit_r <= 1'b0;
			high_voltage_enable_bit_r <= 1'b0;
		end else if (wr_ctl) begin
			program_arm_bit_r <= pgm_wr_val;
			high_voltage_enable_bit_r <= high_voltage_enable_bit_wr_val;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			flash_block_protect_r <= BP_RESET;
		end else if (wr_bp) begin
			flash_block_protect_r <= wdata_r[7:0];
		end
	end

	// Sticky timing error: a new violation wins over a write-one clear
	always_ff @(posedge clk) begin
		if (reset) begin
			timing_err_r <= 1'b0;
		end else begin
			timing_err_r <= timing_err_set || (timing_err_r && !(wr_st && wdata_r[ST_TIMING_ERR_BIT]));
		end
	end

	// ----------------------------------------
	// Write channels
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			aw_have_r <= 1'b0;
			awaddr_r <= '0;
			s_axi_awready <= 1'b1;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_have_r <= 1'b1;
			awaddr_r <= s_axi_awaddr;
			s_axi_awready <= 1'b0;
		end else if (wr_go) begin
			aw_have_r <= 1'b0;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_awready <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			w_have_r <= 1'b0;
			wdata_r <= '0;
			wstrb_r <= '0;
			s_axi_wready <= 1'b1;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_have_r <= 1'b1;
			wdata_r <= s_axi_wdata;
			wstrb_r <= s_axi_wstrb;
			s_axi_wready <= 1'b0;
		end else if (wr_go) begin
			w_have_r <= 1'b0;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_wready <= 1'b1;
		end
	end

	logic wr_mapped;
	assign wr_mapped = wr_idx == FLASH_CONTROL_IDX || wr_idx == FLASH_BLOCK_PROTECT_IDX || wr_idx == SEQ_STATUS_IDX;

	always_ff @(posedge clk) begin
		if (reset) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			if (wr_arr) begin
				s_axi_bresp <= (row_accept || byte_accept) ? RESP_OKAY : RESP_SLVERR;
			end else begin
				s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_DECERR;
			end
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ----------------------------------------
	// Read channel
	// ----------------------------------------
	logic rd_take;
	logic [15:0] rd_idx;
	logic [15:0] rd_arr_idx;
	logic rd_arr;
	assign rd_take = s_axi_arvalid && s_axi_arready;
	assign rd_idx = 16'(s_axi_araddr[ADDR_W-1:2]);
	assign rd_arr_idx = rd_idx - ARRAY_BASE_IDX;
	assign rd_arr = rd_idx >= ARRAY_BASE_IDX && 32'(rd_arr_idx) < ARRAY_BYTES;

	always_ff @(posedge clk) begin
		if (reset) begin
			bp_read_r <= 1'b0;
		end else if (state_r == FRPS_IDLE) begin
			bp_read_r <= 1'b0;
		end else if (rd_take && rd_idx == FLASH_BLOCK_PROTECT_IDX) begin
			bp_read_r <= 1'b1;
		end
	end

	// Array reads are refused while any step runs, recovery included
	always_ff @(posedge clk) begin
		if (reset) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else if (rd_take) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
			if (rd_arr) begin
				if (state_r == FRPS_IDLE) begin
					s_axi_rdata <= {24'h000000, flash_mem[rd_arr_idx[OFF_W-1:0]]};
				end else begin
					s_axi_rresp <= RESP_SLVERR;
				end
			end else if (rd_idx == FLASH_CONTROL_IDX) begin
				s_axi_rdata[CTL_PGM_BIT] <= program_arm_bit_r;
				s_axi_rdata[CTL_HIGH_VOLTAGE_ENABLE_BIT_BIT] <= high_voltage_enable_bit_r;
			end else if (rd_idx == FLASH_BLOCK_PROTECT_IDX) begin
				s_axi_rdata[7:0] <= flash_block_protect_r;
			end else if (rd_idx == SEQ_STATUS_IDX) begin
				s_axi_rdata[ST_STATE_LSB +: 3] <= state_r;
				s_axi_rdata[ST_BP_READ_BIT] <= bp_read_r;
				s_axi_rdata[ST_ROW_SEL_BIT] <= row_sel_r;
				s_axi_rdata[ST_TIMING_ERR_BIT] <= timing_err_r;
				s_axi_rdata[ST_BUSY_BIT] <= state_r != FRPS_IDLE;
			end else begin
				s_axi_rresp <= RESP_DECERR;
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ----------------------------------------
	// Array-facing outputs
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			program_arm <= 1'b0;
			high_voltage_enable <= 1'b0;
			array_readable <= 1'b0;
		end else begin
			program_arm <= program_arm_bit_r;
			high_voltage_enable <= high_voltage_enable_bit_r;
			array_readable <= state_r == FRPS_IDLE;
		end
	end

endmodule : frps_top

// ---- frps_asserts.sv ----
// Port checker for the flash row program sequencer.
// Assumes it is bound to frps_top, one clock, synchronous reset.
`timescale 1ns/1ns
module frps_asserts
	import frps_pkg::*;
#(
	parameter int ADDR_W = 18,
	parameter int ARRAY_BYTES = 8192
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [1:0] s_axi_rresp,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic program_arm,
	input wire logic high_voltage_enable,
	input wire logic array_readable
);
	logic [15:0] ridx;
	logic [15:0] widx;
	logic r_arr;
	logic r_unm;
	logic w_take;
	logic r_take;
	assign ridx = 16'(s_axi_araddr >> 2);
	assign widx = 16'(s_axi_awaddr >> 2);
	assign r_arr = (ridx >= ARRAY_BASE_IDX) && (32'(ridx) < 32'(ARRAY_BASE_IDX) + ARRAY_BYTES);
	assign r_unm = !r_arr && ridx != FLASH_CONTROL_IDX && ridx != FLASH_BLOCK_PROTECT_IDX && ridx != SEQ_STATUS_IDX;
	assign w_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	assign r_take = s_axi_arvalid && s_axi_arready;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// ----------------------------------------
	// Bus and sequencer properties
	// ----------------------------------------
	property p_wr_resp; w_take |-> ##[1:2] s_axi_bvalid; endproperty
	a_wr_resp: assert property (p_wr_resp) else $error("write response late");
	property p_aw_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
	a_aw_block: assert property (p_aw_block) else $error("write taken while response pending");
	property p_rd_lat; r_take |=> s_axi_rvalid && !s_axi_arready; endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read data not one cycle after address");
	property p_decerr; r_take && r_unm |=> s_axi_rresp == RESP_DECERR; endproperty
	a_decerr: assert property (p_decerr) else $error("unmapped read not refused");
	property p_pgm_set; w_take && widx == FLASH_CONTROL_IDX && s_axi_wdata[CTL_PGM_BIT] |-> ##[1:4] program_arm;
	endproperty
	a_pgm_set: assert property (p_pgm_set) else $error("program arm did not follow control write");
	property p_arm_busy; program_arm |-> !array_readable; endproperty
	a_arm_busy: assert property (p_arm_busy) else $error("array readable while armed");
	// Hold-off measured from the visible hv drop, so the window allows the register lag
	property p_recover; $fell(high_voltage_enable) |-> !array_readable [*8] ##[37:47] array_readable; endproperty
	a_recover: assert property (p_recover) else $error("read recovery wait wrong");
	property p_busy_read; r_take && r_arr && high_voltage_enable |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0;
	endproperty
	a_busy_read: assert property (p_busy_read) else $error("array read allowed under high voltage");
endmodule : frps_asserts
bind frps_top frps_asserts #(.ADDR_W(ADDR_W), .ARRAY_BYTES(ARRAY_BYTES)) u_chk (.clk, .reset, .s_axi_awaddr,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
	.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rresp, .s_axi_rdata, .s_axi_rvalid, .program_arm,
	.high_voltage_enable, .array_readable);

// ---- tb_top.sv ----
// Self-checking bench for the flash row program sequencer.
// Assumes a 50 MHz clock and AXI4-Lite access to every register.
`timescale 1ns/1ns
module tb_top
	import frps_pkg::*;
;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [17:0] s_axi_awaddr = 18'h0;
	logic [17:0] s_axi_araddr = 18'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata, d;
	logic program_arm, high_voltage_enable, array_readable;
	int miscompares = 0;
	int checks = 0;
	// Row never written before, so it counts as freshly erased
	localparam logic [15:0] ROW = ARRAY_BASE_IDX + 16'h0040;
	frps_top dut (.clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .program_arm,
		.high_voltage_enable, .array_readable);
	always #10 clk = ~clk;
	// ----------------------------------------
	// Access tasks
	// ----------------------------------------
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %s exp %h seen %h", what, exp, seen);
		end
	endtask : chk
	// The sequence runs from bench tasks, never out of the array itself
	task automatic wr(input logic [15:0] idx, input logic [7:0] v, input logic [1:0] er);
		@(posedge clk);
		s_axi_awaddr <= {idx, 2'h0};
		s_axi_wdata <= {24'h0, v};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk("bresp", 32'(s_axi_bresp), 32'(er));
	endtask : wr
	task automatic rd(input logic [15:0] idx, input logic [1:0] er, output logic [31:0] v);
		@(posedge clk);
		s_axi_araddr <= {idx, 2'h0};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		v = s_axi_rdata;
		chk("rresp", 32'(s_axi_rresp), 32'(er));
	endtask : rd
	task automatic rc(input logic [15:0] idx, input logic [31:0] mask, input logic [31:0] exp);
		rd(idx, RESP_OKAY, d);
		chk("rdata", d & mask, exp);
	endtask : rc
	task automatic give_verdict();
		if (miscompares == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : give_verdict
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		#(20 * 20000);
		miscompares++;
		give_verdict();
	end
	initial begin
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		repeat (3) @(posedge clk);
		chk("readable", 32'(array_readable), 32'h1);
		rc(FLASH_CONTROL_IDX, 32'hFFFFFFFF, 32'h0);
		rc(FLASH_BLOCK_PROTECT_IDX, 32'hFFFFFFFF, 32'h000000FF);
		rc(SEQ_STATUS_IDX, 32'hFFFFFFFF, 32'h0);
		rd(16'h0001, RESP_DECERR, d);
		wr(16'h0001, 8'h55, RESP_DECERR);
		wr(FLASH_BLOCK_PROTECT_IDX, 8'h3C, RESP_OKAY);
		rc(FLASH_BLOCK_PROTECT_IDX, 32'hFFFFFFFF, 32'h0000003C);
		// Arm and disarm before high voltage: must fall back to idle
		wr(FLASH_CONTROL_IDX, 8'h01, RESP_OKAY);
		rc(SEQ_STATUS_IDX, 32'h00000007, 32'h1);
		wr(FLASH_CONTROL_IDX, 8'h00, RESP_OKAY);
		rc(SEQ_STATUS_IDX, 32'h00000007, 32'h0);
		// Row program of one byte with an early and an out-of-row byte on the way
		wr(FLASH_CONTROL_IDX, 8'h01, RESP_OKAY);
		repeat (2) @(posedge clk);
		chk("arm", 32'(program_arm), 32'h1);
		chk("readable", 32'(array_readable), 32'h0);
		rd(FLASH_BLOCK_PROTECT_IDX, RESP_OKAY, d);
		rc(SEQ_STATUS_IDX, 32'h0000000F, 32'h9);
		wr(ROW + 16'h0005, 8'hC3, RESP_OKAY);
		rc(SEQ_STATUS_IDX, 32'h00000017, 32'h13);
		repeat (510) @(posedge clk);
		wr(FLASH_CONTROL_IDX, 8'h09, RESP_OKAY);
		repeat (2) @(posedge clk);
		chk("hv", 32'(high_voltage_enable), 32'h1);
		rd(ROW, RESP_SLVERR, d);
		chk("busy_data", d, 32'h0);
		wr(ROW + 16'h0007, 8'hA5, RESP_SLVERR);
		rc(SEQ_STATUS_IDX, 32'h00000027, 32'h22);
		wr(SEQ_STATUS_IDX, 8'h20, RESP_OKAY);
		rc(SEQ_STATUS_IDX, 32'h00000020, 32'h0);
		repeat (260) @(posedge clk);
		wr(ARRAY_BASE_IDX + 16'h0060, 8'h11, RESP_SLVERR);
		wr(ROW + 16'h0007, 8'h5A, RESP_OKAY);
		rc(SEQ_STATUS_IDX, 32'h00000007, 32'h6);
		repeat (1510) @(posedge clk);
		wr(FLASH_CONTROL_IDX, 8'h08, RESP_OKAY);
		rc(SEQ_STATUS_IDX, 32'h00000007, 32'h7);
		repeat (260) @(posedge clk);
		wr(FLASH_CONTROL_IDX, 8'h00, RESP_OKAY);
		repeat (2) @(posedge clk);
		chk("readable", 32'(array_readable), 32'h0);
		// Still closed 49 cycles after the clearing write: recovery is not cut short
		repeat (47) @(posedge clk);
		chk("readable", 32'(array_readable), 32'h0);
		repeat (13) @(posedge clk);
		chk("readable", 32'(array_readable), 32'h1);
		rc(ROW + 16'h0007, 32'h000000FF, 32'h5A);
		rc(SEQ_STATUS_IDX, 32'h00000007, 32'h0);
		give_verdict();
	end
endmodule : tb_top
